// file: rtl/mic_map.vh
// Constants for the core interrupt controller: option register, vectors, modes.
// Assumes inclusion by bare name from files under rtl/.
`ifndef MIC_MAP_VH
`define MIC_MAP_VH

// ----------------------------------------------------------------------------
// Option register
// ----------------------------------------------------------------------------
`define MIC_OPT_ADDR 8'hC8
`define MIC_OPT_RESET 8'h00
`define MIC_OPT_V1_LEVEL 6
`define MIC_OPT_SYNC_EDGE 5
`define MIC_OPT_GEN 4

// ----------------------------------------------------------------------------
// Vector addresses and source indices
// ----------------------------------------------------------------------------
`define MIC_VEC_NMI 12'hFFC
`define MIC_VEC_1 12'hFF6
`define MIC_VEC_SYNC 12'hFF4
`define MIC_VEC_TMR1 12'hFF2
`define MIC_VEC_TMR2 12'hFF0
`define MIC_SRC_V1 0
`define MIC_SRC_SYNC 1
`define MIC_SRC_TMR1 2
`define MIC_SRC_TMR2 3

// ----------------------------------------------------------------------------
// Flag set selectors
// ----------------------------------------------------------------------------
`define MIC_FS_NORMAL 2'h0
`define MIC_FS_IRQ 2'h1
`define MIC_FS_NMI 2'h2

`endif

// file: rtl/mic_edge_latch.v
// Single-request edge latch: one stored request, extra events are dropped.
// Assumes the input is synchronous to clk_i.
`timescale 1ns/100ps
module mic_edge_latch
(
    input wire clk_i,
    input wire rst_n_i,
    input wire sig_i,
    input wire rise_sel_i,
    input wire enable_i,
    input wire clear_i,
    output reg pend_o
);
    reg prev_r;
    wire edge_seen;

    assign edge_seen = rise_sel_i ? (sig_i & ~prev_r) : (~sig_i & prev_r);

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_r <= 1'b0;
            pend_o <= 1'b0;
        end
        else
        begin
            prev_r <= sig_i;
            // Set wins over a same-cycle clear so no event is lost
            if (enable_i && edge_seen)
                pend_o <= 1'b1;
            else if (clear_i)
                pend_o <= 1'b0;
        end
    end
endmodule

// file: rtl/mic_ret_stack.v
// Hardware return stack for program counter values, register read data.
// Assumes push and pop never coincide; overflow wraps silently.
`timescale 1ns/100ps
module mic_ret_stack
#(
    parameter WIDTH = 12,
    parameter DEPTH = 6,
    parameter PTR_W = 3
)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire push_i,
    input wire pop_i,
    input wire [WIDTH-1:0] push_data_i,
    output reg [WIDTH-1:0] top_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    localparam [31:0] LAST_W = DEPTH - 1;
    localparam [PTR_W-1:0] LAST_IDX = LAST_W[PTR_W-1:0];
    reg [PTR_W-1:0] sp_r;
    wire [PTR_W-1:0] sp_dec;

    // Pointer wraps both ways so it never leaves the array
    assign sp_dec = (sp_r == {PTR_W{1'b0}}) ? LAST_IDX : sp_r - {{(PTR_W-1){1'b0}}, 1'b1};

    always @(posedge clk_i)
    begin
        if (push_i)
            mem_r[sp_r] <= push_data_i;
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sp_r <= {PTR_W{1'b0}};
            top_o <= {WIDTH{1'b0}};
        end
        else if (push_i)
        begin
            sp_r <= (sp_r == LAST_IDX) ? {PTR_W{1'b0}} : sp_r + 1'b1;
            top_o <= push_data_i;
        end
        else if (pop_i)
        begin
            sp_r <= sp_dec;
            top_o <= mem_r[sp_dec];
        end
    end
endmodule

// file: rtl/mic_irq_ctrl.v
// Interrupt controller of the 8-bit core: priority, latching, entry and return.
// Assumes core strobes are one-cycle pulses synchronous to clk_i.
`timescale 1ns/100ps
`include "mic_map.vh"
module mic_irq_ctrl
#(
    parameter PC_W = 12,
    parameter STACK_DEPTH = 6
)
(
    input wire clk_i,
    input wire rst_n_i,
    // Data space write port
    input wire data_wr_i,
    input wire [7:0] data_addr_i,
    input wire [7:0] data_wdata_i,
    // Sources
    input wire infrared_input_pin_i,
    input wire infrared_enable_i,
    input wire vector1_src_i,
    input wire vsync_i,
    input wire vsync_enable_i,
    input wire timer1_request_flag_i,
    input wire timer1_request_mask_i,
    input wire timer2_request_flag_i,
    input wire timer2_request_mask_i,
    // Core sequencer
    input wire last_cycle_i,
    input wire return_from_interrupt_i,
    input wire [PC_W-1:0] pc_i,
    input wire carry_i,
    input wire zero_i,
    input wire flags_we_i,
    output reg irq_take_o,
    output reg [PC_W-1:0] pc_load_o,
    output reg pc_load_en_o,
    output reg [PC_W-1:0] ret_pc_o,
    output reg carry_o,
    output reg zero_o,
    output reg [1:0] flag_set_o,
    output reg timer1_ack_o,
    output reg timer2_ack_o
);

    // ------------------------------------------------------------------------
    // Mode states
    // ------------------------------------------------------------------------
    localparam ST_NORMAL = 3'b001;
    localparam ST_IRQ = 3'b010;
    localparam ST_NMI = 3'b100;

    // ------------------------------------------------------------------------
    // Option register
    // ------------------------------------------------------------------------
    reg v1_level_r;
    reg sync_rise_r;
    reg gen_r;
    wire opt_wr;

    assign opt_wr = data_wr_i && (data_addr_i == `MIC_OPT_ADDR);

    // Write-only: nothing here ever drives read data
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            v1_level_r <= 1'b0;
            sync_rise_r <= 1'b0;
            gen_r <= 1'b0;
        end
        else if (opt_wr)
        begin
            v1_level_r <= data_wdata_i[`MIC_OPT_V1_LEVEL];
            sync_rise_r <= data_wdata_i[`MIC_OPT_SYNC_EDGE];
            gen_r <= data_wdata_i[`MIC_OPT_GEN];
            // Bits 7 and 3..0 are dropped on the floor
        end
    end

    // ------------------------------------------------------------------------
    // Source latches
    // ------------------------------------------------------------------------
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] ret_mode_r;
    reg entry_r;
    reg entry_nmi_r;
    reg [3:0] entry_src_r;
    wire nmi_pend;
    wire v1_edge_pend;
    wire sync_pend;
    wire clr_nmi;
    wire clr_v1;
    wire clr_sync;

    assign clr_nmi = entry_r && entry_nmi_r;
    assign clr_v1 = entry_r && entry_src_r[`MIC_SRC_V1];
    assign clr_sync = entry_r && entry_src_r[`MIC_SRC_SYNC];

    mic_edge_latch u_nmi_latch
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sig_i(infrared_input_pin_i),
        .rise_sel_i(1'b1),
        .enable_i(infrared_enable_i),
        .clear_i(clr_nmi),
        .pend_o(nmi_pend)
    );

    mic_edge_latch u_v1_latch
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sig_i(vector1_src_i),
        .rise_sel_i(1'b0),
        .enable_i(~v1_level_r),
        .clear_i(clr_v1),
        .pend_o(v1_edge_pend)
    );

    // Sync source disabled means its line is held low
    mic_edge_latch u_sync_latch
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sig_i(vsync_i & vsync_enable_i),
        .rise_sel_i(sync_rise_r),
        .enable_i(vsync_enable_i),
        .clear_i(clr_sync),
        .pend_o(sync_pend)
    );

    // ------------------------------------------------------------------------
    // Request vector and priority
    // ------------------------------------------------------------------------
    wire [3:0] raw_req;
    wire [3:0] req;
    wire [3:0] sel;
    wire mask_ok;
    wire take_nmi;
    wire take_mask;

    // Level request on vector 1 must hold through the sampling cycle
    assign raw_req[`MIC_SRC_V1] = v1_level_r ? ~vector1_src_i : v1_edge_pend;
    assign raw_req[`MIC_SRC_SYNC] = sync_pend;
    assign raw_req[`MIC_SRC_TMR1] = timer1_request_flag_i & timer1_request_mask_i;
    assign raw_req[`MIC_SRC_TMR2] = timer2_request_flag_i & timer2_request_mask_i;
    assign req = gen_r ? raw_req : 4'h0;
    assign sel = req & (~req + 4'h1);

    assign mask_ok = (state_r == ST_NORMAL);
    // Keep out of a second entry until the vector cycle is done
    assign take_nmi = last_cycle_i && !entry_r && nmi_pend && (state_r != ST_NMI);
    assign take_mask = last_cycle_i && !entry_r && !take_nmi && mask_ok && (|req);

    function [PC_W-1:0] vec_addr;
        input is_nmi;
        input [3:0] s;
        begin
            if (is_nmi)
                vec_addr = `MIC_VEC_NMI;
            else if (s[`MIC_SRC_V1])
                vec_addr = `MIC_VEC_1;
            else if (s[`MIC_SRC_SYNC])
                vec_addr = `MIC_VEC_SYNC;
            else if (s[`MIC_SRC_TMR1])
                vec_addr = `MIC_VEC_TMR1;
            else
                vec_addr = `MIC_VEC_TMR2;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------------
    wire stk_push;
    wire stk_pop;
    wire [PC_W-1:0] stk_top;

    assign stk_push = take_nmi | take_mask;
    assign stk_pop = return_from_interrupt_i && last_cycle_i && !entry_r;

    mic_ret_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH), .PTR_W(3)) u_stack
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .push_i(stk_push),
        .pop_i(stk_pop),
        .push_data_i(pc_i),
        .top_o(stk_top)
    );

    // ------------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------------
    // Return mode remembers whether the NMI hit normal or interrupt mode
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL:
            begin
                if (take_nmi)
                    state_nxt = ST_NMI;
                else if (take_mask)
                    state_nxt = ST_IRQ;
            end
            ST_IRQ:
            begin
                if (take_nmi)
                    state_nxt = ST_NMI;
                else if (stk_pop)
                    state_nxt = ST_NORMAL;
            end
            ST_NMI:
            begin
                if (stk_pop)
                    state_nxt = (ret_mode_r == `MIC_FS_IRQ) ? ST_IRQ : ST_NORMAL;
            end
            default:
                state_nxt = ST_NMI;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_NMI;
            ret_mode_r <= `MIC_FS_NORMAL;
            entry_r <= 1'b0;
            entry_nmi_r <= 1'b0;
            entry_src_r <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            if (take_nmi)
                ret_mode_r <= (state_r == ST_IRQ) ? `MIC_FS_IRQ : `MIC_FS_NORMAL;
            entry_r <= stk_push;
            entry_nmi_r <= take_nmi;
            entry_src_r <= take_mask ? sel : 4'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Flag sets: normal, interrupt, NMI
    // ------------------------------------------------------------------------
    reg [2:0] carry_set_r;
    reg [2:0] zero_set_r;
    wire [1:0] cur_fs;
    wire [1:0] nxt_fs;

    function [1:0] fs_of;
        input [2:0] st;
        begin
            case (st)
                ST_NORMAL: fs_of = `MIC_FS_NORMAL;
                ST_IRQ: fs_of = `MIC_FS_IRQ;
                default: fs_of = `MIC_FS_NMI;
            endcase
        end
    endfunction

    assign cur_fs = fs_of(state_r);
    assign nxt_fs = fs_of(state_nxt);

    // Banked flags mean the routine never has to save them
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            carry_set_r <= 3'h0;
            zero_set_r <= 3'h0;
        end
        else if (flags_we_i)
        begin
            carry_set_r[cur_fs] <= carry_i;
            zero_set_r[cur_fs] <= zero_i;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs toward the core
    // ------------------------------------------------------------------------
    reg pop_dly_r;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pop_dly_r <= 1'b0;
            irq_take_o <= 1'b0;
            pc_load_o <= {PC_W{1'b0}};
            pc_load_en_o <= 1'b0;
            ret_pc_o <= {PC_W{1'b0}};
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            flag_set_o <= `MIC_FS_NMI;
            timer1_ack_o <= 1'b0;
            timer2_ack_o <= 1'b0;
        end
        else
        begin
            irq_take_o <= stk_push;
            // Vector load is the special cycle after the push
            pc_load_en_o <= entry_r;
            if (stk_push)
                pc_load_o <= vec_addr(take_nmi, sel);
            pop_dly_r <= stk_pop;
            // Stack top holds the popped address one cycle after the pop
            if (pop_dly_r)
                ret_pc_o <= stk_top;
            flag_set_o <= nxt_fs;
            // Write-through keeps outputs current within the same set
            if (flags_we_i && nxt_fs == cur_fs)
            begin
                carry_o <= carry_i;
                zero_o <= zero_i;
            end
            else
            begin
                carry_o <= carry_set_r[nxt_fs];
                zero_o <= zero_set_r[nxt_fs];
            end
            // Timers hold their own latch; ack clears it
            timer1_ack_o <= take_mask && sel[`MIC_SRC_TMR1];
            timer2_ack_o <= take_mask && sel[`MIC_SRC_TMR2];
        end
    end

endmodule

// file: tb/mic_timer_model.sv
// Timer request model: one latched request flag, cleared by the core's ack.
// Assumes fire_i and ack_i are one-cycle pulses synchronous to clk_i.
`timescale 1ns/100ps
module mic_timer_model
(
    input wire clk_i,
    input wire rst_n_i,
    input wire fire_i,
    input wire ack_i,
    output logic flag_o
);
    // Set wins, so a request arriving during service is kept
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_o <= 1'b0;
        else if (fire_i)
            flag_o <= 1'b1;
        else if (ack_i)
            flag_o <= 1'b0;
    end
endmodule

// file: tb/mic_irq_ctrl_assertions.sv
// Checker for the interrupt controller: entry pulses, vectors and modes.
// Assumes it is bound to mic_irq_ctrl and sees only its ports.
`timescale 1ns/100ps
`include "mic_map.vh"
module mic_irq_ctrl_checker
#(
    parameter PC_W = 12
)
(
    input wire clk_i,
    input wire rst_n_i,
    input wire last_cycle_i,
    input wire irq_take_o,
    input wire [PC_W-1:0] pc_load_o,
    input wire pc_load_en_o,
    input wire [1:0] flag_set_o,
    input wire timer1_ack_o,
    input wire timer2_ack_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------
    // Entry sequence
    // ------------------
    property p_take_load;
        irq_take_o |=> pc_load_en_o && $stable(pc_load_o);
    endproperty
    a_take_load: assert property (p_take_load)
        else $error("vector load did not follow take");
    property p_load_cause;
        pc_load_en_o |-> $past(irq_take_o);
    endproperty
    a_load_cause: assert property (p_load_cause)
        else $error("vector load without take");
    property p_take_cause;
        irq_take_o |-> $past(last_cycle_i);
    endproperty
    a_take_cause: assert property (p_take_cause)
        else $error("take outside last cycle");
    property p_no_double;
        irq_take_o |=> !irq_take_o;
    endproperty
    a_no_double: assert property (p_no_double)
        else $error("take twice in a row");
    // ------------------
    // Modes and vectors
    // ------------------
    property p_nmi_blocks;
        irq_take_o |-> $past(flag_set_o) != `MIC_FS_NMI;
    endproperty
    a_nmi_blocks: assert property (p_nmi_blocks)
        else $error("take while in nmi mode");
    property p_no_nest;
        irq_take_o && $past(flag_set_o) == `MIC_FS_IRQ |-> pc_load_o == `MIC_VEC_NMI;
    endproperty
    a_no_nest: assert property (p_no_nest)
        else $error("maskable nested in maskable");
    property p_nmi_vec;
        irq_take_o && flag_set_o == `MIC_FS_NMI |-> pc_load_o == `MIC_VEC_NMI;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("nmi flag set with wrong vector");
    property p_t1_ack;
        timer1_ack_o |-> irq_take_o && pc_load_o == `MIC_VEC_TMR1;
    endproperty
    a_t1_ack: assert property (p_t1_ack)
        else $error("timer one ack out of place");
    property p_t2_ack;
        timer2_ack_o |-> irq_take_o && pc_load_o == `MIC_VEC_TMR2;
    endproperty
    a_t2_ack: assert property (p_t2_ack)
        else $error("timer two ack out of place");
    c_nmi: cover property (irq_take_o && pc_load_o == `MIC_VEC_NMI);
    c_tmr1: cover property (timer1_ack_o);
    c_sync: cover property (irq_take_o && pc_load_o == `MIC_VEC_SYNC);
endmodule

// file: tb/mcu_interrupt_controller_tb_top.sv
// Bench for the interrupt controller: boot mode, priority, nesting, masks.
// Assumes the timer model and checker files are compiled before it.
`timescale 1ns/100ps
`include "mic_map.vh"
module mcu_interrupt_controller_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic data_wr_i = 1'b0;
    logic [7:0] data_addr_i = 8'h00;
    logic [7:0] data_wdata_i = 8'h00;
    logic ir_pin = 1'b0;
    logic ir_en = 1'b1;
    logic vs_en = 1'b1;
    logic v1_src = 1'b1;
    logic [11:0] pc = 12'h5A3;
    wire [11:0] ret_pc_o;
    logic vsync_i = 1'b1;
    logic fire1 = 1'b0;
    logic fire2 = 1'b0;
    logic mask1 = 1'b1;
    logic mask2 = 1'b1;
    logic last_cycle_i = 1'b0;
    logic rfi = 1'b0;
    logic carry_i = 1'b0;
    logic zero_i = 1'b0;
    logic flags_we_i = 1'b0;
    wire flag1, flag2, irq_take_o, pc_load_en_o, carry_o, zero_o, ack1, ack2;
    wire [11:0] pc_load_o;
    wire [1:0] flag_set_o;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc_count = 0;

    always #20 clk_i = ~clk_i;

    mic_irq_ctrl mic_irq_ctrl_inst
    (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .data_wr_i(data_wr_i),
        .data_addr_i(data_addr_i), .data_wdata_i(data_wdata_i),
        .infrared_input_pin_i(ir_pin), .infrared_enable_i(ir_en),
        .vector1_src_i(v1_src), .vsync_i(vsync_i), .vsync_enable_i(vs_en),
        .timer1_request_flag_i(flag1), .timer1_request_mask_i(mask1),
        .timer2_request_flag_i(flag2), .timer2_request_mask_i(mask2),
        .last_cycle_i(last_cycle_i), .return_from_interrupt_i(rfi),
        .pc_i(pc), .carry_i(carry_i), .zero_i(zero_i), .flags_we_i(flags_we_i),
        .irq_take_o(irq_take_o), .pc_load_o(pc_load_o), .pc_load_en_o(pc_load_en_o),
        .ret_pc_o(ret_pc_o), .carry_o(carry_o), .zero_o(zero_o), .flag_set_o(flag_set_o),
        .timer1_ack_o(ack1), .timer2_ack_o(ack2)
    );
    mic_timer_model tmr1_inst
        (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire1), .ack_i(ack1), .flag_o(flag1));
    mic_timer_model tmr2_inst
        (.clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire2), .ack_i(ack2), .flag_o(flag2));

    task automatic chk(input logic [11:0] exp, input logic [11:0] got, input string nm);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        data_wr_i = 1'b1;
        data_addr_i = a;
        data_wdata_i = d;
        @(negedge clk_i);
        data_wr_i = 1'b0;
    endtask

    task automatic fire_t(input logic a, input logic b);
        @(negedge clk_i);
        fire1 = a;
        fire2 = b;
        @(negedge clk_i);
        fire1 = 1'b0;
        fire2 = 1'b0;
    endtask

    // One instruction end; take shows one cycle later, vector load one after that
    task automatic step(input logic ret, input logic take, input logic [11:0] vec);
        @(negedge clk_i);
        last_cycle_i = 1'b1;
        rfi = ret;
        @(negedge clk_i);
        last_cycle_i = 1'b0;
        rfi = 1'b0;
        chk(take, irq_take_o, "take");
        if (take)
            chk(vec, pc_load_o, "vector");
        @(negedge clk_i);
        chk(take, pc_load_en_o, "load");
    endtask

    task automatic t_boot;
        chk(`MIC_FS_NMI, flag_set_o, "reset mode");
        wr(`MIC_OPT_ADDR, 8'h10);
        fire_t(1'b1, 1'b0);
        step(1'b0, 1'b0, 12'h000);
        step(1'b1, 1'b0, 12'h000);
        chk(`MIC_FS_NORMAL, flag_set_o, "normal mode");
    endtask

    task automatic t_nest;
        @(negedge clk_i);
        flags_we_i = 1'b1;
        carry_i = 1'b1;
        zero_i = 1'b1;
        @(negedge clk_i);
        flags_we_i = 1'b0;
        fire_t(1'b0, 1'b1);
        step(1'b0, 1'b1, `MIC_VEC_TMR1);
        chk(`MIC_FS_IRQ, flag_set_o, "irq mode");
        chk(1'b0, carry_o, "irq carry");
        step(1'b0, 1'b0, 12'h000);
        ir_pin = 1'b1;
        pc = 12'h3C1;
        step(1'b0, 1'b1, `MIC_VEC_NMI);
        ir_pin = 1'b0;
        pc = 12'h111;
        chk(`MIC_FS_NMI, flag_set_o, "nmi mode");
        step(1'b1, 1'b0, 12'h000);
        chk(`MIC_FS_IRQ, flag_set_o, "back to irq");
        chk(12'h3C1, ret_pc_o, "ret pc nmi");
        step(1'b1, 1'b0, 12'h000);
        chk(`MIC_FS_NORMAL, flag_set_o, "back to normal");
        chk(12'h5A3, ret_pc_o, "ret pc irq");
        chk(1'b1, carry_o, "normal carry");
        chk(1'b1, zero_o, "normal zero");
        step(1'b0, 1'b1, `MIC_VEC_TMR2);
        step(1'b1, 1'b0, 12'h000);
    endtask

    task automatic t_mask;
        mask2 = 1'b0;
        fire_t(1'b0, 1'b1);
        step(1'b0, 1'b0, 12'h000);
        mask2 = 1'b1;
        step(1'b0, 1'b1, `MIC_VEC_TMR2);
        step(1'b1, 1'b0, 12'h000);
    endtask

    // Two falling edges while pending give one request; level mode last
    task automatic t_vec1;
        fire_t(1'b1, 1'b0);
        v1_src = 1'b0;
        @(negedge clk_i);
        v1_src = 1'b1;
        @(negedge clk_i);
        v1_src = 1'b0;
        step(1'b0, 1'b1, `MIC_VEC_1);
        step(1'b1, 1'b0, 12'h000);
        step(1'b0, 1'b1, `MIC_VEC_TMR1);
        step(1'b1, 1'b0, 12'h000);
        wr(`MIC_OPT_ADDR, 8'h50);
        step(1'b0, 1'b1, `MIC_VEC_1);
        v1_src = 1'b1;
        step(1'b1, 1'b0, 12'h000);
        step(1'b0, 1'b0, 12'h000);
        wr(`MIC_OPT_ADDR, 8'h10);
    endtask

    task automatic t_gen;
        wr(`MIC_OPT_ADDR, 8'h00);
        vsync_i = 1'b0;
        step(1'b0, 1'b0, 12'h000);
        wr(8'hC9, 8'h10);
        step(1'b0, 1'b0, 12'h000);
        wr(`MIC_OPT_ADDR, 8'h9F);
        step(1'b0, 1'b1, `MIC_VEC_SYNC);
        step(1'b1, 1'b0, 12'h000);
        wr(`MIC_OPT_ADDR, 8'h30);
        vsync_i = 1'b1;
        step(1'b0, 1'b1, `MIC_VEC_SYNC);
        step(1'b1, 1'b0, 12'h000);
        step(1'b0, 1'b0, 12'h000);
        vs_en = 1'b0;
        ir_en = 1'b0;
        vsync_i = 1'b0;
        ir_pin = 1'b1;
        @(negedge clk_i);
        vsync_i = 1'b1;
        ir_pin = 1'b0;
        @(negedge clk_i);
        vsync_i = 1'b0;
        @(negedge clk_i);
        vs_en = 1'b1;
        ir_en = 1'b1;
        step(1'b0, 1'b0, 12'h000);
    endtask

    // Run takes about 120 cycles; the ceiling of 3000 leaves ample margin
    always @(posedge clk_i)
    begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 3000)
        begin
            bad_count++;
            finish_test;
        end
    end

    initial
    begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_boot;
        t_nest;
        t_mask;
        t_vec1;
        t_gen;
        finish_test;
    end
endmodule

bind mic_irq_ctrl mic_irq_ctrl_checker #(.PC_W(PC_W)) mic_irq_ctrl_checker_inst
(
    .clk_i(clk_i), .rst_n_i(rst_n_i), .last_cycle_i(last_cycle_i),
    .irq_take_o(irq_take_o), .pc_load_o(pc_load_o), .pc_load_en_o(pc_load_en_o),
    .flag_set_o(flag_set_o), .timer1_ack_o(timer1_ack_o), .timer2_ack_o(timer2_ack_o)
);
